/* File: logic/ufc_pkg.sv */
package ufc_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] OFF_IER = 4'h1;
  localparam logic [3:0] OFF_FCR = 4'h2;
  localparam logic [3:0] OFF_MCR = 4'h4;
  localparam logic [3:0] OFF_FIFO_RDY = 4'h7;
  localparam logic [3:0] OFF_EFR = 4'h8;
  localparam logic [3:0] OFF_DLL = 4'h9;
  localparam logic [3:0] OFF_DLH = 4'ha;
  localparam logic [3:0] OFF_TCR = 4'hb;
  localparam logic [3:0] OFF_TLR = 4'hc;
  localparam logic [3:0] OFF_STAT = 4'hd;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_IER = 8'h00;
  localparam logic [7:0] RST_FCR = 8'h00;
  localparam logic [7:0] RST_MCR = 8'h00;
  localparam logic [7:0] RST_EFR = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_TCR = 8'h00;
  localparam logic [7:0] RST_TLR = 8'h00;

  // ==========================================================
  // Field positions
  localparam int EFR_CTS_EN = 7;
  localparam int EFR_RTS_EN = 6;
  localparam int EFR_SPEC_EN = 5;
  localparam int EFR_ENH = 4;
  localparam int IER_SLEEP = 4;
  localparam int MCR_RTS = 1;
  localparam int MCR_RDY_EN = 2;
  localparam int MCR_LOOP = 4;
  localparam int MCR_REG_EN = 6;
  localparam int FCR_RX_LSB = 6;
  localparam int FCR_TX_LSB = 4;

  // Bits that only change while the enhanced write enable is set
  localparam logic [7:0] IER_ENH_MASK = 8'hf0;
  localparam logic [7:0] FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK = 8'he0;

  // ==========================================================
  // Fallback trigger levels selected by the two control bits
  localparam logic [6:0] FCR_LVL_0 = 7'h08;
  localparam logic [6:0] FCR_LVL_1 = 7'h10;
  localparam logic [6:0] FCR_LVL_2 = 7'h20;
  localparam logic [6:0] FCR_LVL_3 = 7'h38;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wrStb;
    logic rdStb;
  } ufc_bus_req_t;

  typedef struct packed {
    logic [6:0] rxLevel;
    logic [6:0] txSpace;
  } ufc_fifo_lvl_t;

  typedef struct packed {
    logic rxB;
    logic rxA;
    logic txB;
    logic txA;
  } ufc_rdy_t;

  typedef enum logic [1:0] {
    RTS_OPEN = 2'b01,
    RTS_HALTED = 2'b10
  } ufc_rts_state_t;

  // Four-bit field in steps of four
  function automatic logic [6:0] lvl_x4(input logic [3:0] f);
    lvl_x4 = {1'b0, f, 2'b00};
  endfunction

endpackage

/* File: logic/ufc_level_sel.sv */
`timescale 1ns/10ps
module ufc_level_sel (
  input wire logic [3:0] tlrField,
  input wire logic [1:0] fcrSel,
  input wire logic [6:0] level,
  output logic [6:0] trigLvl,
  output logic hit
);

  // ==========================================================
  // Level selection
  always_comb begin
    // [R14] zero field falls back
    if (tlrField != 4'h0) begin
      // [R19] field times four
      trigLvl = ufc_pkg::lvl_x4(tlrField);
    end else begin
      case (fcrSel)
        2'b00: trigLvl = ufc_pkg::FCR_LVL_0;
        2'b01: trigLvl = ufc_pkg::FCR_LVL_1;
        2'b10: trigLvl = ufc_pkg::FCR_LVL_2;
        default: trigLvl = ufc_pkg::FCR_LVL_3;
      endcase
    end
  end

  // [R12] level reached
  assign hit = (level >= trigLvl);

endmodule

/* File: logic/ufc_config.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
// ==========================================================
// Behaviour
// [R1] CTS high halts transmit when enabled
// [R2] RTS high at halt, low at resume
// [R3] All flow features off after reset
// [R4] Match second stop char, store, flag
// [R5] Enhanced bit gates enhanced field writes
// [R6] Low four bits pick software flow mode
// [R7] Divisor is high byte then low byte
// [R8] Divisor writes only outside sleep mode
// [R9] Threshold: resume high nibble, halt low
// [R10] Threshold writes need enhanced and MCR6
// [R11] Host keeps halt above resume
// [R12] Trigger: rx high nibble, tx low
// [R13] Trigger writes need enhanced and MCR6
// [R14] Zero trigger field uses control register
// [R15] Host leaves rx control bits at zero
// [R16] Ready bits 5,4,1,0; others zero
// [R17] Ready register at 111 when enabled
// [R18] Special-character flag reads as one
// [R19] Effective level is field times four
// [R20] Ready bits sampled every cycle
module ufc_config (
  input wire logic mclk,
  input wire logic nrst,
  input wire ufc_pkg::ufc_bus_req_t busReq,
  output logic [7:0] rdData,
  input wire logic chanASelN,
  input wire logic chanBSelN,
  input wire logic ctsPinN,
  output logic rtsPinN,
  output logic txHalt,
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic [7:0] xoff2Char,
  output logic rxFifoWr,
  input wire logic specCharClr,
  output logic specCharFlag,
  input wire ufc_pkg::ufc_fifo_lvl_t fifoLvl,
  input wire ufc_pkg::ufc_rdy_t rdyIn,
  output logic rxTrigHit,
  output logic txTrigHit,
  output logic [15:0] divisor,
  output logic [3:0] swFlowMode,
  output logic sleepEn,
  output logic loopEn
);

  logic [7:0] ierQ;
  logic [7:0] fcrQ;
  logic [7:0] mcrQ;
  logic [7:0] efrQ;
  logic [7:0] dllQ;
  logic [7:0] dlhQ;
  logic [7:0] tcrQ;
  logic [7:0] tlrQ;
  logic [7:0] fifoRdyQ;
  logic [7:0] rdDataQ;
  logic ctsMeta;
  logic ctsSync;
  logic specQ;
  logic rtsPinQ;
  ufc_pkg::ufc_rts_state_t rtsStateQ;
  ufc_pkg::ufc_rts_state_t rtsStateD;
  logic [6:0] haltLvl;
  logic [6:0] resumeLvl;
  logic wrIer;
  logic wrFcr;
  logic wrMcr;
  logic wrDiv;
  logic cfgWrEn;
  logic rdyVisible;
  logic specMatch;

  // Keeps gated bits and takes the rest
  function automatic logic [7:0] gated_wr(input logic [7:0] oldV, input logic [7:0] newV,
                                          input logic [7:0] mask, input logic en);
    gated_wr = en ? newV : ((oldV & mask) | (newV & ~mask));
  endfunction

  // ==========================================================
  // Write decode
  assign wrIer = busReq.wrStb && (busReq.addr == ufc_pkg::OFF_IER);
  assign wrFcr = busReq.wrStb && (busReq.addr == ufc_pkg::OFF_FCR);
  assign wrMcr = busReq.wrStb && (busReq.addr == ufc_pkg::OFF_MCR);
  // [R8] no divisor writes in sleep
  assign wrDiv = !ierQ[ufc_pkg::IER_SLEEP];
  // [R10] [R13] shared write gate
  assign cfgWrEn = efrQ[ufc_pkg::EFR_ENH] && mcrQ[ufc_pkg::MCR_REG_EN];

  // ==========================================================
  // Base registers with enhanced write gating
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ierQ <= ufc_pkg::RST_IER;
      fcrQ <= ufc_pkg::RST_FCR;
      mcrQ <= ufc_pkg::RST_MCR;
    end else begin
      // [R5] enhanced bits write enable
      if (wrIer) begin
        ierQ <= gated_wr(ierQ, busReq.wdata, ufc_pkg::IER_ENH_MASK, efrQ[ufc_pkg::EFR_ENH]);
      end
      if (wrFcr) begin
        fcrQ <= gated_wr(fcrQ, busReq.wdata, ufc_pkg::FCR_ENH_MASK, efrQ[ufc_pkg::EFR_ENH]);
      end
      if (wrMcr) begin
        mcrQ <= gated_wr(mcrQ, busReq.wdata, ufc_pkg::MCR_ENH_MASK, efrQ[ufc_pkg::EFR_ENH]);
      end
    end
  end

  // ==========================================================
  // Enhanced feature register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      // [R3] flow features off
      efrQ <= ufc_pkg::RST_EFR;
    end else if (busReq.wrStb && (busReq.addr == ufc_pkg::OFF_EFR)) begin
      efrQ <= busReq.wdata;
    end
  end

  // [R6] software flow selection
  assign swFlowMode = efrQ[3:0];
  assign sleepEn = ierQ[ufc_pkg::IER_SLEEP];
  assign loopEn = mcrQ[ufc_pkg::MCR_LOOP];

  // ==========================================================
  // Divisor latches
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dllQ <= ufc_pkg::RST_DIV;
      dlhQ <= ufc_pkg::RST_DIV;
    end else if (busReq.wrStb && wrDiv) begin
      if (busReq.addr == ufc_pkg::OFF_DLL) begin
        dllQ <= busReq.wdata;
      end
      if (busReq.addr == ufc_pkg::OFF_DLH) begin
        dlhQ <= busReq.wdata;
      end
    end
  end

  // [R7] high byte on top
  assign divisor = {dlhQ, dllQ};

  // ==========================================================
  // Threshold and trigger registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tcrQ <= ufc_pkg::RST_TCR;
      tlrQ <= ufc_pkg::RST_TLR;
    end else if (busReq.wrStb && cfgWrEn) begin
      // [R10] gated threshold write
      if (busReq.addr == ufc_pkg::OFF_TCR) begin
        tcrQ <= busReq.wdata;
      end
      // [R13] gated trigger write
      if (busReq.addr == ufc_pkg::OFF_TLR) begin
        tlrQ <= busReq.wdata;
      end
    end
  end

  // [R9] [R19] nibble levels times four
  assign haltLvl = ufc_pkg::lvl_x4(tcrQ[3:0]);
  assign resumeLvl = ufc_pkg::lvl_x4(tcrQ[7:4]);

  // ==========================================================
  // Trigger selection, receive and transmit
  // [R12] [R14] per-direction selection
  ufc_level_sel uRxSel (
    .tlrField(tlrQ[7:4]),
    .fcrSel(fcrQ[ufc_pkg::FCR_RX_LSB +: 2]),
    .level(fifoLvl.rxLevel),
    .trigLvl(),
    .hit(rxTrigHit)
  );

  ufc_level_sel uTxSel (
    .tlrField(tlrQ[3:0]),
    .fcrSel(fcrQ[ufc_pkg::FCR_TX_LSB +: 2]),
    .level(fifoLvl.txSpace),
    .trigLvl(),
    .hit(txTrigHit)
  );

  // ==========================================================
  // Clear-to-send pin
  // Pin is asynchronous to mclk, so two stages before use
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctsMeta <= 1'b0;
      ctsSync <= 1'b0;
    end else begin
      ctsMeta <= ctsPinN;
      ctsSync <= ctsMeta;
    end
  end

  // [R1] halt while pin high
  assign txHalt = efrQ[ufc_pkg::EFR_CTS_EN] && ctsSync;

  // ==========================================================
  // Request-to-send flow control
  always_comb begin
    rtsStateD = rtsStateQ;
    case (rtsStateQ)
      ufc_pkg::RTS_OPEN: begin
        if (fifoLvl.rxLevel >= haltLvl) begin
          rtsStateD = ufc_pkg::RTS_HALTED;
        end
      end
      ufc_pkg::RTS_HALTED: begin
        if (fifoLvl.rxLevel <= resumeLvl) begin
          rtsStateD = ufc_pkg::RTS_OPEN;
        end
      end
      default: rtsStateD = ufc_pkg::RTS_OPEN;
    endcase
  end

  // Hysteresis depends on halt above resume; equal levels chatter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rtsStateQ <= ufc_pkg::RTS_OPEN;
    end else if (!efrQ[ufc_pkg::EFR_RTS_EN]) begin
      rtsStateQ <= ufc_pkg::RTS_OPEN;
    end else begin
      // [R2] halt and resume levels
      rtsStateQ <= rtsStateD;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rtsPinQ <= 1'b1;
    end else if (efrQ[ufc_pkg::EFR_RTS_EN]) begin
      // [R2] pin follows flow state
      rtsPinQ <= (rtsStateD == ufc_pkg::RTS_HALTED);
    end else begin
      rtsPinQ <= !mcrQ[ufc_pkg::MCR_RTS];
    end
  end

  assign rtsPinN = rtsPinQ;

  // ==========================================================
  // Special character detection
  assign specMatch = efrQ[ufc_pkg::EFR_SPEC_EN] && rxCharValid && (rxChar == xoff2Char);
  // [R4] matched character still stored
  assign rxFifoWr = rxCharValid;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      specQ <= 1'b0;
    end else if (specMatch) begin
      // [R4] [R18] set wins over clear
      specQ <= 1'b1;
    end else if (specCharClr) begin
      specQ <= 1'b0;
    end
  end

  assign specCharFlag = specQ;

  // ==========================================================
  // FIFO ready status
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fifoRdyQ <= 8'h00;
    end else begin
      // [R16] [R20] live sample, unused zero
      fifoRdyQ <= {2'b00, rdyIn.rxB, rdyIn.rxA, 2'b00, rdyIn.txB, rdyIn.txA};
    end
  end

  // [R17] visibility conditions
  assign rdyVisible = (!chanASelN || !chanBSelN) && mcrQ[ufc_pkg::MCR_RDY_EN] &&
                      !mcrQ[ufc_pkg::MCR_LOOP];

  // ==========================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdDataQ <= 8'h00;
    end else if (busReq.rdStb) begin
      case (busReq.addr)
        ufc_pkg::OFF_IER: rdDataQ <= ierQ;
        ufc_pkg::OFF_FCR: rdDataQ <= fcrQ;
        ufc_pkg::OFF_MCR: rdDataQ <= mcrQ;
        // [R17] gated ready read
        ufc_pkg::OFF_FIFO_RDY: rdDataQ <= rdyVisible ? fifoRdyQ : 8'h00;
        ufc_pkg::OFF_EFR: rdDataQ <= efrQ;
        ufc_pkg::OFF_DLL: rdDataQ <= dllQ;
        ufc_pkg::OFF_DLH: rdDataQ <= dlhQ;
        ufc_pkg::OFF_TCR: rdDataQ <= tcrQ;
        ufc_pkg::OFF_TLR: rdDataQ <= tlrQ;
        ufc_pkg::OFF_STAT: rdDataQ <= {3'b000, specQ, rxTrigHit, txTrigHit, txHalt,
                                       rtsStateQ == ufc_pkg::RTS_HALTED};
        default: rdDataQ <= 8'h00;
      endcase
    end else begin
      rdDataQ <= 8'h00;
    end
  end

  assign rdData = rdDataQ;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  AST_CTS_HALT: assert property (efrQ[7] && ctsSync |-> txHalt) // R1
    else $error("transmit not halted while clear-to-send high");
  AST_CTS_OFF: assert property (!efrQ[7] |-> !txHalt) // R1
    else $error("transmit halted with flow control off");
  AST_RTS_HALT: assert property (efrQ[6] && $past(efrQ[6]) && fifoLvl.rxLevel >= haltLvl
                                 |=> rtsPinN) // R2
    else $error("request-to-send not raised at halt level");
  AST_RTS_RESUME: assert property (efrQ[6] && rtsStateQ == ufc_pkg::RTS_HALTED &&
                                   fifoLvl.rxLevel <= resumeLvl |=> !rtsPinN) // R2
    else $error("request-to-send not lowered at resume level");
  AST_RST_DEFAULT: assert property (!$past(nrst) |-> efrQ[7:5] == 3'b000) // R3
    else $error("flow features enabled after reset");
  AST_SPEC_SET: assert property (specMatch |=> specCharFlag) // R4
    else $error("special character not flagged");
  AST_IER_GATE: assert property (wrIer && !efrQ[4] |=> ierQ[7:4] == $past(ierQ[7:4])) // R5
    else $error("gated interrupt enable bits changed");
  AST_MCR_GATE: assert property (wrMcr && !efrQ[4] |=> mcrQ[7:5] == $past(mcrQ[7:5])) // R5
    else $error("gated modem control bits changed");
  AST_DIV_GATE: assert property (ierQ[4] |=> $stable(divisor)) // R8
    else $error("divisor written during sleep");
  AST_TCR_GATE: assert property (!cfgWrEn |=> $stable(tcrQ)) // R10
    else $error("threshold written without enable");
  AST_TLR_GATE: assert property (!cfgWrEn |=> $stable(tlrQ)) // R13
    else $error("trigger written without enable");
  AST_RDY_READ: assert property (busReq.rdStb && busReq.addr == 4'h7 && rdyVisible
                                 |=> rdData[7:6] == 2'b00 && rdData[3:2] == 2'b00 &&
                                 rdData[5] == $past(fifoRdyQ[5])) // R16
    else $error("ready register read wrong");
  AST_RDY_LIVE: assert property (##1 fifoRdyQ[0] == $past(rdyIn.txA)) // R20
    else $error("ready status not sampled");

endmodule

/* File: tb/ufc_remote_dev.sv */
`timescale 1ns/10ps
// ==========================================================
// Far-side serial device
module ufc_remote_dev (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic rtsPinN,
  input wire logic holdReq,
  input wire logic sendReq,
  input wire logic [7:0] sendChar,
  output logic ctsPinN = 1'b0,
  output logic rxCharValid = 1'b0,
  output logic [7:0] rxChar = 8'h00
);
  // Hold CTS high to stop us
  always @(posedge mclk) begin
    if (!nrst) begin
      ctsPinN <= 1'b0;
    end else begin
      ctsPinN <= holdReq;
    end
  end

  // Sender obeys RTS halt
  // Data toggles between characters so a stale value is never mistaken for one
  always @(posedge mclk) begin
    if (!nrst) begin
      rxCharValid <= 1'b0;
      rxChar <= 8'h00;
    end else if (sendReq && !rtsPinN) begin
      rxCharValid <= 1'b1;
      rxChar <= sendChar;
    end else begin
      rxCharValid <= 1'b0;
      rxChar <= ~rxChar;
    end
  end
endmodule

/* File: tb/ufc_config_test.sv */
`timescale 1ns/10ps
module ufc_config_test;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  ufc_pkg::ufc_bus_req_t busReq = '0;
  ufc_pkg::ufc_fifo_lvl_t fifoLvl = '0;
  ufc_pkg::ufc_rdy_t rdyIn = '0;
  logic chanASelN = 1'b1;
  logic chanBSelN = 1'b1;
  logic specCharClr = 1'b0;
  logic [7:0] xoff2Char = 8'h13;
  logic holdReq = 1'b0;
  logic sendReq = 1'b0;
  logic [7:0] sendChar = 8'h00;
  logic [7:0] rdData, rxChar, rd;
  logic ctsPinN, rtsPinN, txHalt, rxCharValid, rxFifoWr, specCharFlag;
  logic rxTrigHit, txTrigHit, sleepEn, loopEn;
  logic [15:0] divisor;
  logic [3:0] swFlowMode;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [6:0] rtsLvl [5] = '{7'd10, 7'd31, 7'd32, 7'd9, 7'd8};
  logic rtsExp [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  ufc_config dut_u (.mclk(mclk), .nrst(nrst), .busReq(busReq), .rdData(rdData),
    .chanASelN(chanASelN), .chanBSelN(chanBSelN), .ctsPinN(ctsPinN), .rtsPinN(rtsPinN),
    .txHalt(txHalt), .rxCharValid(rxCharValid), .rxChar(rxChar), .xoff2Char(xoff2Char),
    .rxFifoWr(rxFifoWr), .specCharClr(specCharClr), .specCharFlag(specCharFlag),
    .fifoLvl(fifoLvl), .rdyIn(rdyIn), .rxTrigHit(rxTrigHit), .txTrigHit(txTrigHit),
    .divisor(divisor), .swFlowMode(swFlowMode), .sleepEn(sleepEn), .loopEn(loopEn));

  ufc_remote_dev remote_u (.mclk(mclk), .nrst(nrst), .rtsPinN(rtsPinN), .holdReq(holdReq),
    .sendReq(sendReq), .sendChar(sendChar), .ctsPinN(ctsPinN), .rxCharValid(rxCharValid),
    .rxChar(rxChar));

  always #4 mclk = ~mclk;

  // ==========================================================
  // Checking
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Bus and stimulus
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge mclk);
    busReq.wrStb <= 1'b0;
    #1;
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge mclk);
    busReq.rdStb <= 1'b0;
    #1;
    rd = rdData;
    chkReg(rd & exp, exp);
    chkReg(rd & ~exp, 8'h00);
  endtask

  task automatic trig(input logic [7:0] fifo_trigger_level, input logic [7:0] fifo_control_reg, input logic [6:0] rx,
                      input logic [6:0] tx, input logic eRx, input logic eTx);
    wr(ufc_pkg::OFF_TLR, fifo_trigger_level);
    wr(ufc_pkg::OFF_FCR, fifo_control_reg);
    @(posedge mclk);
    fifoLvl <= '{rxLevel: rx, txSpace: tx};
    settle(1);
    chkPin(rxTrigHit, eRx);
    chkPin(txTrigHit, eTx);
  endtask

  task automatic sendCh(input logic [7:0] c);
    @(posedge mclk);
    sendReq <= 1'b1;
    sendChar <= c;
    @(posedge mclk);
    sendReq <= 1'b0;
    #1;
    chkPin(rxFifoWr, 1'b1);
    settle(1);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    settle(1);
    chkPin(rtsPinN, 1'b1);
    chkPin(txHalt, 1'b0);
    chkPin(specCharFlag, 1'b0);
    for (int i = 8; i <= 12; i++) rdChk(4'(i), 8'h00);
    wr(ufc_pkg::OFF_IER, 8'hff);
    rdChk(ufc_pkg::OFF_IER, 8'h0f);
    wr(ufc_pkg::OFF_MCR, 8'he0);
    rdChk(ufc_pkg::OFF_MCR, 8'h00);
    wr(ufc_pkg::OFF_FCR, 8'h30);
    rdChk(ufc_pkg::OFF_FCR, 8'h00);
    wr(ufc_pkg::OFF_EFR, 8'h10);
    wr(ufc_pkg::OFF_TCR, 8'h28);
    rdChk(ufc_pkg::OFF_TCR, 8'h00);
    wr(ufc_pkg::OFF_TLR, 8'h35);
    rdChk(ufc_pkg::OFF_TLR, 8'h00);
    wr(ufc_pkg::OFF_MCR, 8'h40);
    wr(ufc_pkg::OFF_TCR, 8'h28);
    rdChk(ufc_pkg::OFF_TCR, 8'h28);
    wr(ufc_pkg::OFF_TLR, 8'h35);
    rdChk(ufc_pkg::OFF_TLR, 8'h35);
    wr(ufc_pkg::OFF_IER, 8'hf0);
    rdChk(ufc_pkg::OFF_IER, 8'hf0);
    chkPin(sleepEn, 1'b1);
    wr(ufc_pkg::OFF_DLL, 8'h34);
    rdChk(ufc_pkg::OFF_DLL, 8'h00);
    wr(ufc_pkg::OFF_IER, 8'h00);
    wr(ufc_pkg::OFF_DLL, 8'h34);
    wr(ufc_pkg::OFF_DLH, 8'h12);
    chkReg(divisor[15:8], 8'h12);
    chkReg(divisor[7:0], 8'h34);
    wr(ufc_pkg::OFF_EFR, 8'h1a);
    chkReg({4'h0, swFlowMode}, 8'h0a);
    trig(8'h35, 8'h00, 7'd11, 7'd19, 1'b0, 1'b0);
    trig(8'h35, 8'h00, 7'd12, 7'd20, 1'b1, 1'b1);
    trig(8'h00, 8'h00, 7'd7, 7'd7, 1'b0, 1'b0);
    trig(8'h00, 8'h00, 7'd8, 7'd8, 1'b1, 1'b1);
    trig(8'h00, 8'hf0, 7'd55, 7'd55, 1'b0, 1'b0);
    trig(8'h00, 8'hf0, 7'd56, 7'd56, 1'b1, 1'b1);
    trig(8'h30, 8'h30, 7'd12, 7'd55, 1'b1, 1'b0);
    wr(ufc_pkg::OFF_EFR, 8'h50);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      fifoLvl.rxLevel <= rtsLvl[i];
      settle(1);
      chkPin(rtsPinN, rtsExp[i]);
    end
    wr(ufc_pkg::OFF_EFR, 8'h90);
    @(posedge mclk);
    holdReq <= 1'b1;
    settle(5);
    chkPin(txHalt, 1'b1);
    wr(ufc_pkg::OFF_EFR, 8'h10);
    chkPin(txHalt, 1'b0);
    @(posedge mclk);
    holdReq <= 1'b0;
    wr(ufc_pkg::OFF_EFR, 8'h30);
    wr(ufc_pkg::OFF_MCR, 8'h42);
    sendCh(8'h11);
    chkPin(specCharFlag, 1'b0);
    sendCh(8'h13);
    chkPin(specCharFlag, 1'b1);
    rdChk(ufc_pkg::OFF_STAT, 8'h10);
    @(posedge mclk);
    specCharClr <= 1'b1;
    @(posedge mclk);
    specCharClr <= 1'b0;
    wr(ufc_pkg::OFF_EFR, 8'h10);
    sendCh(8'h13);
    chkPin(specCharFlag, 1'b0);
    wr(ufc_pkg::OFF_MCR, 8'h44);
    @(posedge mclk);
    chanASelN <= 1'b0;
    rdyIn <= '{rxB: 1'b1, rxA: 1'b0, txB: 1'b1, txA: 1'b0};
    rdChk(ufc_pkg::OFF_FIFO_RDY, 8'h22);
    @(posedge mclk);
    chanASelN <= 1'b1;
    chanBSelN <= 1'b0;
    rdyIn <= '{rxB: 1'b0, rxA: 1'b1, txB: 1'b0, txA: 1'b1};
    wr(ufc_pkg::OFF_FIFO_RDY, 8'hff);
    rdChk(ufc_pkg::OFF_FIFO_RDY, 8'h11);
    chkReg(rd, 8'h11);
    wr(ufc_pkg::OFF_MCR, 8'h54);
    chkPin(loopEn, 1'b1);
    rdChk(ufc_pkg::OFF_FIFO_RDY, 8'h00);
    chkReg(rd, 8'h00);
    wr(ufc_pkg::OFF_MCR, 8'h40);
    rdChk(ufc_pkg::OFF_FIFO_RDY, 8'h00);
    chkReg(rd, 8'h00);
    wr(ufc_pkg::OFF_MCR, 8'h44);
    @(posedge mclk);
    chanBSelN <= 1'b1;
    rdChk(ufc_pkg::OFF_FIFO_RDY, 8'h00);
    chkReg(rd, 8'h00);
    rdChk(4'hf, 8'h00);
    chkReg(rd, 8'h00);
    print_verdict();
  end
endmodule
